// *** jfc_dbg_model.sv ***
`timescale 1ns/1ps
// Debugger model that owns TMS and the test pin
module jfc_dbg_model (
    input  wire mclk_i,
    output reg  tms_o,
    output reg  test_o
);
    // Idle levels: TMS high, test pin low
    initial begin
        tms_o = 1'b1;
        test_o = 1'b0;
    end
    // Pin changes land on the falling edge, away from sampling
    task drive(input logic t, input logic p);
        @(negedge mclk_i);
        tms_o = t;
        test_o = p;
    endtask
endmodule // jfc_dbg_model

// *** jfc_jtag_fuse_check_sequencer.v ***
// Operation
// - Run fuse continuity check on first test-port access after each power-on reset.
// - Activate on first TMS falling edge, or when TMS is low at power-up.
// - Deactivate on the second TMS rising edge counted from power-up.
// - After deactivation stay inactive until next power-on reset re-arms.
// - Sense current enabled only while mode active and TMS low.
// - Test pin driven low again ends the mode and stops current.
// - Protection granted only with fuse blown and boot_loader key required.
`timescale 1ns/1ps
`include "jfc_regs.vh"

// Two-flip-flop synchroniser for one asynchronous pin.
// Only the second stage leaves the module, so no logic ever
// reads a possibly metastable first stage.
module jfc_pin_sync #(
    parameter [0:0] RST_VAL = `JFC_OUT_OFF
) (
    input  wire mclk_i,
    input  wire rst_i,
    input  wire pin_i,
    output reg  sync_o
);

    reg meta_r;

    // First stage catches the pin, second stage hands it on
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_r <= pin_i;
            sync_o <= meta_r;
        end
    end

endmodule // jfc_pin_sync

// Fuse check sequencer. The mode arms at power-on, turns on at the first
// synchronised TMS fall and is locked off by the second TMS rise or by a
// drop of the test pin. Pins pass two flip-flops, so every response lags
// the pin by three clock edges; TMS pulses shorter than one cycle may be
// missed. Only rst_i, the power-on reset, re-arms the sequence.
// Sense current follows the mode and the synchronised TMS level.
module jfc_jtag_fuse_check_sequencer (
    input  wire mclk_i,
    input  wire rst_i,
    input  wire tms_i,
    input  wire test_pin_i,
    input  wire fuse_blown_i,
    input  wire key_required_i,
    output reg  fuse_check_active_o,
    output reg  sense_current_en_o,
    output reg  protect_ok_o
);

    // One-hot mode states
    localparam [`JFC_ST_W-1:0] ST_ARMED  = `JFC_ST_ARMED;
    localparam [`JFC_ST_W-1:0] ST_ACTIVE = `JFC_ST_ACTIVE;
    localparam [`JFC_ST_W-1:0] ST_SEEN1  = `JFC_ST_SEEN1;
    localparam [`JFC_ST_W-1:0] ST_DONE   = `JFC_ST_DONE;

    // Synchronised pin levels
    wire                  tms_sync;
    wire                  test_sync;
    wire                  fuse_sync;
    wire                  key_sync;

    // Delayed levels for edge detection
    reg                   tms_d_r;
    reg                   test_d_r;

    // Mode state and rising-edge count
    reg [`JFC_ST_W-1:0]   state_r;
    reg [`JFC_ST_W-1:0]   state_nxt;
    reg [`JFC_RISE_W-1:0] rise_r;
    reg [`JFC_RISE_W-1:0] rise_nxt;

    // Decoded edges and next output values
    wire                  tms_fall;
    wire                  tms_rise;
    wire                  test_fall;
    wire                  act_nxt;
    wire                  sense_nxt;
    wire                  protect_nxt;

    // TMS resets to its idle high level, so a pin held low through power-up
    // appears as a falling edge once the stages fill
    jfc_pin_sync #(
        .RST_VAL (`JFC_TMS_IDLE)
    ) u_jfc_pin_sync_tms (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .pin_i   (tms_i),
        .sync_o  (tms_sync)
    );

    // Test pin idles low, so power-up never looks like a falling edge
    jfc_pin_sync #(
        .RST_VAL (`JFC_TEST_IDLE)
    ) u_jfc_pin_sync_test (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .pin_i   (test_pin_i),
        .sync_o  (test_sync)
    );

    // Fuse status is a slow level, synchronised anyway
    // because it may change while the clock runs
    jfc_pin_sync #(
        .RST_VAL (`JFC_OUT_OFF)
    ) u_jfc_pin_sync_fuse (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .pin_i   (fuse_blown_i),
        .sync_o  (fuse_sync)
    );

    // Key requirement is a level as well; off until seen
    // through both stages
    jfc_pin_sync #(
        .RST_VAL (`JFC_OUT_OFF)
    ) u_jfc_pin_sync_key (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .pin_i   (key_required_i),
        .sync_o  (key_sync)
    );

    // One-cycle delay of the synchronised levels for edge detection
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tms_d_r  <= `JFC_TMS_IDLE;
            test_d_r <= `JFC_TEST_IDLE;
        end else begin
            tms_d_r  <= tms_sync;
            test_d_r <= test_sync;
        end
    end

    // Edge detectors on synchronised levels
    assign tms_fall  = tms_d_r & ~tms_sync;
    assign tms_rise  = ~tms_d_r & tms_sync;
    assign test_fall = test_d_r & ~test_sync;

    // Rising edges of TMS counted from power-up, saturating at the end count;
    // rises before activation count too
    always @* begin
        rise_nxt = rise_r;
        if (tms_rise && rise_r != `JFC_RISE_END) begin
            rise_nxt = rise_r + `JFC_RISE_ONE;
        end
    end

    // Mode sequencing: armed, active, one rise seen, done
    always @* begin
        state_nxt = state_r;
        case (state_r)
            // Waiting for the first TMS fall since power-on
            ST_ARMED: begin
                if (tms_fall) begin
                    state_nxt = ST_ACTIVE;
                end else if (rise_nxt == `JFC_RISE_END) begin
                    state_nxt = ST_DONE;
                end
            end
            // Mode on; a test pin drop or the counted rise ends it
            ST_ACTIVE: begin
                if (test_fall || rise_nxt == `JFC_RISE_END) begin
                    state_nxt = ST_DONE;
                end else if (tms_rise) begin
                    state_nxt = ST_SEEN1;
                end
            end
            // Mode still on after the first rise
            ST_SEEN1: begin
                if (test_fall || rise_nxt == `JFC_RISE_END) begin
                    state_nxt = ST_DONE;
                end
            end
            // Locked off until the next power-on reset
            ST_DONE: begin
                state_nxt = ST_DONE;
            end
            // Illegal code falls back to the mode off
            default: begin
                state_nxt = ST_DONE;
            end
        endcase
    end

    // Mode flag, sense enable and protection status for the output registers
    assign act_nxt     = (state_nxt == ST_ACTIVE) || (state_nxt == ST_SEEN1);
    assign sense_nxt   = act_nxt & ~tms_sync;
    assign protect_nxt = fuse_sync & key_sync;

    // Mode state, cleared only by power-on reset
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_ARMED;
            rise_r  <= `JFC_RISE_ZERO;
        end else begin
            state_r <= state_nxt;
            rise_r  <= rise_nxt;
        end
    end

    // Registered outputs, all off while reset is applied;
    // each output comes straight from a flip-flop
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            fuse_check_active_o <= `JFC_OUT_OFF;
            sense_current_en_o  <= `JFC_OUT_OFF;
            protect_ok_o        <= `JFC_OUT_OFF;
        end else begin
            fuse_check_active_o <= act_nxt;
            sense_current_en_o  <= sense_nxt;
            protect_ok_o        <= protect_nxt;
        end
    end

endmodule // jfc_jtag_fuse_check_sequencer

// *** jfc_props.sv ***
`timescale 1ns/1ps
module jfc_props (
    input wire mclk_i,
    input wire rst_i,
    input wire tms_i,
    input wire test_pin_i,
    input wire fuse_blown_i,
    input wire key_required_i,
    input wire fuse_check_active_o,
    input wire sense_current_en_o,
    input wire protect_ok_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic off_r;
    // Remembers that the mode has ended since power-on
    always @(posedge mclk_i or posedge rst_i)
        if (rst_i) off_r <= 1'b0;
        else if ($fell(fuse_check_active_o)) off_r <= 1'b1;
    sequence s_tst_drop;
        $fell(test_pin_i) && fuse_check_active_o;
    endsequence
    a_sense_needs_mode: assert property (sense_current_en_o |-> fuse_check_active_o)
        else $error("sense without mode");
    a_sense_tms_low: assert property (sense_current_en_o |-> !$past(tms_i, 3))
        else $error("sense with TMS high");
    a_rise_with_sense: assert property ($rose(fuse_check_active_o) |-> sense_current_en_o)
        else $error("mode started without TMS low");
    a_drop_has_cause: assert property ($fell(fuse_check_active_o) |->
        $past(tms_i, 3) || !$past(test_pin_i, 3)) else $error("mode ended without cause");
    a_test_ends_mode: assert property (s_tst_drop |-> ##[1:4] !fuse_check_active_o)
        else $error("test pin low did not end mode");
    a_stay_off: assert property (off_r |-> !fuse_check_active_o)
        else $error("mode returned before power-on");
    a_protect_and: assert property (protect_ok_o |->
        $past(fuse_blown_i && key_required_i, 3)) else $error("protection without fuse and key");
    a_reset_clear: assert property (disable iff (1'b0) rst_i |-> !fuse_check_active_o)
        else $error("mode set in reset");
endmodule // jfc_props

// *** jfc_regs.vh ***
`ifndef JFC_REGS_VH
`define JFC_REGS_VH
// State encodings (one-hot)
`define JFC_ST_W        4
`define JFC_ST_ARMED    4'h1
`define JFC_ST_ACTIVE   4'h2
`define JFC_ST_SEEN1    4'h4
`define JFC_ST_DONE     4'h8
// Rising-edge count at which the mode ends
`define JFC_RISE_W      2
`define JFC_RISE_ZERO   2'h0
`define JFC_RISE_ONE    2'h1
`define JFC_RISE_END    2'h2
// Synchroniser reset level for TMS (idle high) and test pin
`define JFC_TMS_IDLE    1'h1
`define JFC_TEST_IDLE   1'h0
// Reset level of status synchronisers and registered outputs
`define JFC_OUT_OFF     1'h0
`endif

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic   mclk_i = 1'b0, rst_i = 1'b0, fb = 1'b0, kr = 1'b0;
    wire    tms, tst, act, sen, prt;
    integer fail_count = 0, total_checks = 0;
    jfc_jtag_fuse_check_sequencer u_jfc_jtag_fuse_check_sequencer (.mclk_i(mclk_i),
        .rst_i(rst_i), .tms_i(tms), .test_pin_i(tst), .fuse_blown_i(fb), .key_required_i(kr),
        .fuse_check_active_o(act), .sense_current_en_o(sen), .protect_ok_o(prt));
    jfc_dbg_model u_jfc_dbg_model (.mclk_i(mclk_i), .tms_o(tms), .test_o(tst));
    initial forever #4 mclk_i = ~mclk_i;
    task chk(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask
    // Power-on reset for 4 cycles with TMS at level t
    task por(input logic t);
        u_jfc_dbg_model.drive(t, 1'b1);
        rst_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        chk("act", 1'b0, act);
        rst_i = 1'b0;
    endtask
    task step(input logic t, input logic p);
        u_jfc_dbg_model.drive(t, p);
        repeat (6) @(negedge mclk_i);
    endtask
    // TMS low through power-up, then the test pin ends the mode
    task s_pwr_low;
        por(1'b0);
        step(1'b0, 1'b1);
        chk("act", 1'b1, act);
        step(1'b0, 1'b0);
        chk("act", 1'b0, act);
        chk("sen", 1'b0, sen);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        chk("act", 1'b0, act);
    endtask
    // Fall, rise, fall, rise, fall on TMS after a fresh power-on
    task s_walk;
        por(1'b1);
        step(1'b0, 1'b1);
        chk("act", 1'b1, act);
        chk("sen", 1'b1, sen);
        step(1'b1, 1'b1);
        chk("sen", 1'b0, sen);
        chk("act", 1'b1, act);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        chk("act", 1'b0, act);
        step(1'b0, 1'b1);
        chk("sen", 1'b0, sen);
        chk("act", 1'b0, act);
    endtask
    // Every fuse and key combination
    task s_prot;
        for (int i = 0; i < 4; i++) begin
            fb = i[0];
            kr = i[1];
            repeat (6) @(negedge mclk_i);
            chk("prt", i == 3, prt);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        s_pwr_low;
        s_walk;
        s_prot;
        print_verdict;
    end
endmodule // tb_top
bind jfc_jtag_fuse_check_sequencer jfc_props u_jfc_props (.*);
